/* lmc_regs.sv */
/*
 * Mission control register bank of a temperature and humidity logger:
 * alarm enables and sticky flags, oscillator control, logging setup,
 * mission state machine and log start addresses.
 * Assumes register access, commands and conversion results arrive as
 * single-cycle strobes synchronous to clk_i from the command decoder.
 */
module lmc_regs (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic        reg_wr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic [7:0]       reg_rdata_o,
	input  wire logic        cmd_clear_mem_i,
	input  wire logic        cmd_start_i,
	input  wire logic        cmd_stop_i,
	input  wire logic        cmd_force_conv_i,
	input  wire logic        temp_valid_i,
	input  wire logic [7:0]  temp_msb_i,
	input  wire logic        hum_valid_i,
	input  wire logic [7:0]  hum_msb_i,
	input  wire logic        log_full_i,
	output logic             osc_enable_o,
	output logic             sample_unit_seconds_o,
	output logic             mission_active_o,
	output logic             conv_enable_o,
	output logic             conv_8bit_o,
	output logic             temp_wide_o,
	output logic             hum_wide_o,
	output logic             log_write_o,
	output logic             sample_count_inc_o,
	output logic             log_wrap_o,
	output logic [15:0]      temp_base_o,
	output logic [15:0]      hum_base_o,
	output lmc_pkg::lmc_state_t state_o
);
	import lmc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	logic [7:0]  temp_lo_thr_r;
	logic [7:0]  temp_hi_thr_r;
	logic [7:0]  hum_lo_thr_r;
	logic [7:0]  hum_hi_thr_r;
	logic [1:0]  temp_en_r;
	logic [1:0]  hum_en_r;
	logic        osc_en_r;
	logic        unit_sec_r;
	logic [5:0]  setup_r;
	logic [3:0]  flags_r;
	logic        batt_r;
	logic        cleared_r;
	logic        await_r;
	lmc_state_t  state_r;
	lmc_state_t  state_nxt;
	logic [7:0]  rdata_r;
	logic        active_r;
	logic        conv_en_r;
	logic        conv8_r;
	logic        log_write_r;
	logic        count_inc_r;
	logic        wrap_r;
	logic [15:0] temp_base_r;
	logic [15:0] hum_base_r;

	////////////////////////////////////////////////////////////////////////
	// Decode
	wire logic        wr_open   = reg_wr_i & state_r == LMC_IDLE;
	wire logic        wr_tlo    = wr_open & reg_addr_i == LMC_ADDR_TEMP_LO_THR;
	wire logic        wr_thi    = wr_open & reg_addr_i == LMC_ADDR_TEMP_HI_THR;
	wire logic        wr_hlo    = wr_open & reg_addr_i == LMC_ADDR_HUM_LO_THR;
	wire logic        wr_hhi    = wr_open & reg_addr_i == LMC_ADDR_HUM_HI_THR;
	wire logic        wr_tctl   = wr_open & reg_addr_i == LMC_ADDR_TEMP_CTL;
	wire logic        wr_hctl   = wr_open & reg_addr_i == LMC_ADDR_HUM_CTL;
	wire logic        wr_osc    = wr_open & reg_addr_i == LMC_ADDR_OSC_CTL;
	wire logic        wr_setup  = wr_open & reg_addr_i == LMC_ADDR_LOG_SETUP;
	wire logic        st_idle   = state_r == LMC_IDLE;
	wire logic        st_wait   = state_r == LMC_WAIT;
	wire logic        st_log    = state_r == LMC_LOG;
	wire logic        tlog      = setup_r[LMC_BIT_TEMP_LOG];
	wire logic        hlog      = setup_r[LMC_BIT_HUM_LOG];
	wire logic        wrap_en   = setup_r[LMC_BIT_WRAP];
	wire logic        start_alarm_eff = setup_r[LMC_BIT_START_ALARM] & tlog;
	wire logic        start_ok  = cmd_start_i & st_idle & (tlog | hlog) & cleared_r;
	wire logic        clear_ok  = cmd_clear_mem_i & st_idle;
	wire logic        temp_evt  = temp_valid_i & (st_wait | st_log);
	wire logic        hum_evt   = hum_valid_i & st_log;
	wire logic        sample_evt = st_log & (tlog ? temp_valid_i : hum_valid_i);

	////////////////////////////////////////////////////////////////////////
	// Alarm channels: index 0 temperature, 1 humidity
	lmc_alarm_if alm_if [2] ();

	assign alm_if[0].thr_lo = temp_lo_thr_r;
	assign alm_if[0].thr_hi = temp_hi_thr_r;
	assign alm_if[0].sample = temp_msb_i;
	assign alm_if[0].en_lo  = temp_en_r[LMC_BIT_ALM_LO];
	assign alm_if[0].en_hi  = temp_en_r[LMC_BIT_ALM_HI];
	assign alm_if[0].valid  = temp_evt;
	assign alm_if[1].thr_lo = hum_lo_thr_r;
	assign alm_if[1].thr_hi = hum_hi_thr_r;
	assign alm_if[1].sample = hum_msb_i;
	assign alm_if[1].en_lo  = hum_en_r[LMC_BIT_ALM_LO];
	assign alm_if[1].en_hi  = hum_en_r[LMC_BIT_ALM_HI];
	assign alm_if[1].valid  = hum_evt;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_alm
			lmc_alarm_cmp u_cmp (
				.bus (alm_if[g])
			);
		end
	endgenerate

	wire logic [3:0] hits = {alm_if[1].hit_hi, alm_if[1].hit_lo, alm_if[0].hit_hi, alm_if[0].hit_lo};
	wire logic       temp_alarm = alm_if[0].hit_hi | alm_if[0].hit_lo;
	wire logic       trig       = st_wait & temp_alarm;

	////////////////////////////////////////////////////////////////////////
	// Mission sequencing
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			LMC_IDLE: begin
				if (start_ok)
					state_nxt = start_alarm_eff ? LMC_WAIT : LMC_LOG;
			end
			LMC_WAIT: begin
				if (cmd_stop_i)
					state_nxt = LMC_IDLE;
				else if (trig)
					state_nxt = LMC_LOG;
			end
			LMC_LOG: begin
				if (cmd_stop_i)
					state_nxt = LMC_IDLE;
				else if (log_full_i & ~wrap_en)
					state_nxt = LMC_HALT;
			end
			LMC_HALT: begin
				if (cmd_stop_i)
					state_nxt = LMC_IDLE;
			end
			default: state_nxt = LMC_IDLE;
		endcase
	end

	// Held-off trigger sample is logged but not counted
	wire logic log_write_nxt = sample_evt | trig;
	wire logic count_inc_nxt = sample_evt;
	wire logic wrap_nxt      = st_log & log_full_i & wrap_en & ~cmd_stop_i;
	wire logic osc_nxt       = (cmd_force_conv_i | cmd_start_i) ? 1'b1 :
		(wr_osc ? reg_wdata_i[LMC_BIT_OSC_EN] : osc_en_r);
	// Hardware set wins over a same-cycle clear
	wire logic [3:0] flags_nxt = hits | (flags_r & {4{~clear_ok}});
	wire logic cleared_nxt = start_ok ? 1'b0 : (clear_ok | cleared_r);
	wire logic await_nxt   = (start_ok & start_alarm_eff) ? 1'b1 :
		(temp_alarm ? 1'b0 : await_r);
	wire logic [15:0] tbase_w;
	wire logic [15:0] hbase_w;

	lmc_log_base u_base (
		.temp_log_i  (tlog),
		.hum_log_i   (hlog),
		.temp_wide_i (setup_r[LMC_BIT_TEMP_WIDE]),
		.hum_wide_i  (setup_r[LMC_BIT_HUM_WIDE]),
		.temp_base_o (tbase_w),
		.hum_base_o  (hbase_w)
	);

	////////////////////////////////////////////////////////////////////////
	// Read mux
	wire logic [7:0] rd_flags = LMC_FLAGS_FIXED | {batt_r, 3'h0, flags_r};
	wire logic [7:0] rd_state = LMC_STATE_FIXED | {3'h0, await_r, cleared_r, 1'b0,
		~st_idle, 1'b0};
	wire logic [7:0] rd_mux =
		(reg_addr_i == LMC_ADDR_TEMP_LO_THR)   ? temp_lo_thr_r :
		(reg_addr_i == LMC_ADDR_TEMP_HI_THR)   ? temp_hi_thr_r :
		(reg_addr_i == LMC_ADDR_HUM_LO_THR)    ? hum_lo_thr_r :
		(reg_addr_i == LMC_ADDR_HUM_HI_THR)    ? hum_hi_thr_r :
		(reg_addr_i == LMC_ADDR_TEMP_CTL)      ? (LMC_TEMP_CTL_FIXED | {6'h00, temp_en_r}) :
		(reg_addr_i == LMC_ADDR_HUM_CTL)       ? (LMC_HUM_CTL_FIXED | {6'h00, hum_en_r}) :
		(reg_addr_i == LMC_ADDR_OSC_CTL)       ? (LMC_OSC_FIXED | {6'h00, unit_sec_r, osc_en_r}) :
		(reg_addr_i == LMC_ADDR_LOG_SETUP)     ? (LMC_SETUP_FIXED | {2'h0, setup_r}) :
		(reg_addr_i == LMC_ADDR_ALARM_FLAGS)   ? rd_flags :
		(reg_addr_i == LMC_ADDR_MISSION_STATE) ? rd_state : 8'h00;

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			temp_lo_thr_r <= LMC_THR_RST;
			temp_hi_thr_r <= LMC_THR_RST;
			hum_lo_thr_r  <= LMC_THR_RST;
			hum_hi_thr_r  <= LMC_THR_RST;
			temp_en_r     <= LMC_CTL2_RST;
			hum_en_r      <= LMC_CTL2_RST;
			unit_sec_r    <= 1'b0;
			setup_r       <= LMC_SETUP_RST;
		end else begin
			if (wr_tlo) temp_lo_thr_r <= reg_wdata_i;
			if (wr_thi) temp_hi_thr_r <= reg_wdata_i;
			if (wr_hlo) hum_lo_thr_r <= reg_wdata_i;
			if (wr_hhi) hum_hi_thr_r <= reg_wdata_i;
			if (wr_tctl) temp_en_r <= reg_wdata_i[1:0];
			if (wr_hctl) hum_en_r <= reg_wdata_i[1:0];
			if (wr_osc) unit_sec_r <= reg_wdata_i[LMC_BIT_UNIT_SEC];
			if (wr_setup) setup_r <= reg_wdata_i[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Status and mission registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			osc_en_r  <= 1'b0;
			flags_r   <= LMC_FLAGS_RST;
			batt_r    <= LMC_BATT_RST;
			cleared_r <= 1'b0;
			await_r   <= 1'b0;
			state_r   <= LMC_IDLE;
		end else begin
			osc_en_r  <= osc_nxt;
			flags_r   <= flags_nxt;
			batt_r    <= batt_r & ~clear_ok;
			cleared_r <= cleared_nxt;
			await_r   <= await_nxt;
			state_r   <= state_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_r     <= 8'h00;
			active_r    <= 1'b0;
			conv_en_r   <= 1'b0;
			conv8_r     <= 1'b0;
			log_write_r <= 1'b0;
			count_inc_r <= 1'b0;
			wrap_r      <= 1'b0;
			temp_base_r <= LMC_LOG_BASE;
			hum_base_r  <= LMC_LOG_BASE;
		end else begin
			rdata_r     <= rd_mux;
			active_r    <= state_nxt != LMC_IDLE;
			conv_en_r   <= state_nxt == LMC_WAIT || state_nxt == LMC_LOG;
			conv8_r     <= state_nxt == LMC_WAIT;
			log_write_r <= log_write_nxt;
			count_inc_r <= count_inc_nxt;
			wrap_r      <= wrap_nxt;
			temp_base_r <= tbase_w;
			hum_base_r  <= hbase_w;
		end
	end

	assign reg_rdata_o           = rdata_r;
	assign osc_enable_o          = osc_en_r;
	assign sample_unit_seconds_o = unit_sec_r;
	assign mission_active_o      = active_r;
	assign conv_enable_o         = conv_en_r;
	assign conv_8bit_o           = conv8_r;
	assign temp_wide_o           = setup_r[LMC_BIT_TEMP_WIDE];
	assign hum_wide_o            = setup_r[LMC_BIT_HUM_WIDE];
	assign log_write_o           = log_write_r;
	assign sample_count_inc_o    = count_inc_r;
	assign log_wrap_o            = wrap_r;
	assign temp_base_o           = temp_base_r;
	assign hum_base_o            = hum_base_r;
	assign state_o               = state_r;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_good_start;
		cmd_start_i && st_idle && (tlog || hlog) && cleared_r;
	endsequence
	sequence s_trigger;
		st_wait && temp_valid_i && temp_alarm;
	endsequence

	a_osc_zero_bits: assert property ((reg_addr_i == LMC_ADDR_OSC_CTL) |=> reg_rdata_o[7:2] == 6'h00)
		else $error("oscillator control upper bits not zero");
	a_osc_locked: assert property (!st_idle && reg_wr_i && reg_addr_i == LMC_ADDR_OSC_CTL |=> $stable(sample_unit_seconds_o))
		else $error("oscillator control written during mission");
	a_temp_hi_set: assert property (temp_evt && temp_en_r[1] && temp_msb_i >= temp_hi_thr_r |=> flags_r[1])
		else $error("temperature high flag not set");
	a_temp_hi_gate: assert property (!temp_en_r[1] && !flags_r[1] |=> !flags_r[1])
		else $error("temperature high flag set while disabled");
	a_hum_lo_set: assert property (hum_evt && hum_en_r[0] && hum_msb_i <= hum_lo_thr_r |=> flags_r[2])
		else $error("humidity low flag not set");
	a_force_osc: assert property (cmd_force_conv_i |=> osc_enable_o)
		else $error("forced conversion left oscillator off");
	// A stop right after the start may end the mission one cycle later
	a_start_ok: assert property (s_good_start |=> (mission_active_o && !cleared_r)
		##1 (mission_active_o || $past(cmd_stop_i)))
		else $error("mission start did not take effect");
	a_no_start: assert property (cmd_start_i && st_idle && !tlog && !hlog |=> !mission_active_o)
		else $error("mission started with no log enabled");
	a_trigger_log: assert property (s_trigger |=> log_write_o && !sample_count_inc_o && !await_r)
		else $error("trigger sample handling wrong");
	a_halt_hold: assert property (st_log && log_full_i && !wrap_en && !cmd_stop_i |=> mission_active_o && !conv_enable_o)
		else $error("full log did not halt conversions");
	a_clear_flags: assert property (clear_ok && hits == 4'h0 |=> flags_r == 4'h0 && !batt_r)
		else $error("clear memory left alarm flags set");
	a_wrap_pulse: assert property (st_log && log_full_i && wrap_en && !cmd_stop_i |=> log_wrap_o)
		else $error("full log did not rewind");
	a_await_hold: assert property (await_r && !temp_alarm |=> await_r)
		else $error("awaiting alarm bit lost without an alarm");

endmodule

/* lmc_pkg.sv */
/*
 * Constants shared by the logger mission control register bank: register
 * offsets, bit positions, fixed read bits, reset values, log bases, states.
 * Assumes a 16-bit register address space and 8-bit register data.
 */
package lmc_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [15:0] LMC_ADDR_TEMP_LO_THR  = 16'h0208;
	localparam logic [15:0] LMC_ADDR_TEMP_HI_THR  = 16'h0209;
	localparam logic [15:0] LMC_ADDR_HUM_LO_THR   = 16'h020A;
	localparam logic [15:0] LMC_ADDR_HUM_HI_THR   = 16'h020B;
	localparam logic [15:0] LMC_ADDR_TEMP_CTL     = 16'h0210;
	localparam logic [15:0] LMC_ADDR_HUM_CTL      = 16'h0211;
	localparam logic [15:0] LMC_ADDR_OSC_CTL      = 16'h0212;
	localparam logic [15:0] LMC_ADDR_LOG_SETUP    = 16'h0213;
	localparam logic [15:0] LMC_ADDR_ALARM_FLAGS  = 16'h0214;
	localparam logic [15:0] LMC_ADDR_MISSION_STATE = 16'h0215;

	////////////////////////////////////////////////////////////////////////
	// Bit positions
	localparam int LMC_BIT_ALM_LO      = 0;
	localparam int LMC_BIT_ALM_HI      = 1;
	localparam int LMC_BIT_OSC_EN      = 0;
	localparam int LMC_BIT_UNIT_SEC    = 1;
	localparam int LMC_BIT_TEMP_LOG    = 0;
	localparam int LMC_BIT_HUM_LOG     = 1;
	localparam int LMC_BIT_TEMP_WIDE   = 2;
	localparam int LMC_BIT_HUM_WIDE    = 3;
	localparam int LMC_BIT_WRAP        = 4;
	localparam int LMC_BIT_START_ALARM = 5;
	localparam int LMC_BIT_TEMP_LO_FLG = 0;
	localparam int LMC_BIT_TEMP_HI_FLG = 1;
	localparam int LMC_BIT_HUM_LO_FLG  = 2;
	localparam int LMC_BIT_HUM_HI_FLG  = 3;
	localparam int LMC_BIT_BATT_FLG    = 7;
	localparam int LMC_BIT_ACTIVE      = 1;
	localparam int LMC_BIT_CLEARED     = 3;
	localparam int LMC_BIT_AWAIT       = 4;

	////////////////////////////////////////////////////////////////////////
	// Fixed read bits and reset values
	localparam logic [7:0] LMC_TEMP_CTL_FIXED  = 8'h00;
	localparam logic [7:0] LMC_HUM_CTL_FIXED   = 8'hFC;
	localparam logic [7:0] LMC_OSC_FIXED       = 8'h00;
	localparam logic [7:0] LMC_SETUP_FIXED     = 8'hC0;
	localparam logic [7:0] LMC_FLAGS_FIXED     = 8'h70;
	localparam logic [7:0] LMC_STATE_FIXED     = 8'hC0;
	localparam logic [7:0] LMC_THR_RST         = 8'h00;
	localparam logic [1:0] LMC_CTL2_RST        = 2'h0;
	localparam logic [5:0] LMC_SETUP_RST       = 6'h00;
	localparam logic [3:0] LMC_FLAGS_RST       = 4'h0;
	localparam logic       LMC_BATT_RST        = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Log start addresses
	localparam logic [15:0] LMC_LOG_BASE       = 16'h1000;
	localparam logic [15:0] LMC_HUM_BASE_SAME  = 16'h2000;
	localparam logic [15:0] LMC_HUM_BASE_T8H16 = 16'h1A00;
	localparam logic [15:0] LMC_HUM_BASE_T16H8 = 16'h2400;

	typedef enum logic [3:0] {
		LMC_IDLE = 4'h1,
		LMC_WAIT = 4'h2,
		LMC_LOG  = 4'h4,
		LMC_HALT = 4'h8
	} lmc_state_t;

endpackage

/* lmc_alarm_if.sv */
/*
 * Carrier between the register bank and one alarm comparator channel.
 * Assumes the sample byte is the most significant byte of a conversion.
 */
interface lmc_alarm_if;
	logic [7:0] thr_lo;
	logic [7:0] thr_hi;
	logic [7:0] sample;
	logic       en_lo;
	logic       en_hi;
	logic       valid;
	logic       hit_lo;
	logic       hit_hi;

	modport cmp (input thr_lo, input thr_hi, input sample, input en_lo, input en_hi, input valid,
		output hit_lo, output hit_hi);
	modport ctl (output thr_lo, output thr_hi, output sample, output en_lo, output en_hi, output valid,
		input hit_lo, input hit_hi);
endinterface

/* lmc_alarm_cmp.sv */
/*
 * One alarm channel: inclusive threshold compares gated by the enables.
 * Assumes valid is only raised for samples that may raise alarms.
 */
module lmc_alarm_cmp (
	lmc_alarm_if.cmp bus
);
	import lmc_pkg::*;

	// Inclusive compares on the top byte only
	assign bus.hit_hi = bus.valid & bus.en_hi & (bus.sample >= bus.thr_hi);
	assign bus.hit_lo = bus.valid & bus.en_lo & (bus.sample <= bus.thr_lo);
endmodule

/* lmc_log_base.sv */
/*
 * Start addresses of the temperature and humidity logs from the setup bits.
 * Assumes the caller registers the result.
 */
module lmc_log_base (
	input  wire logic        temp_log_i,
	input  wire logic        hum_log_i,
	input  wire logic        temp_wide_i,
	input  wire logic        hum_wide_i,
	output logic [15:0]      temp_base_o,
	output logic [15:0]      hum_base_o
);
	import lmc_pkg::*;

	wire logic [15:0] both_base;

	assign temp_base_o = LMC_LOG_BASE;
	assign both_base   = (temp_wide_i == hum_wide_i) ? LMC_HUM_BASE_SAME :
		(hum_wide_i ? LMC_HUM_BASE_T8H16 : LMC_HUM_BASE_T16H8);
	assign hum_base_o  = temp_log_i ? both_base : LMC_LOG_BASE;
endmodule

/* lmc_host_model.sv */
/*
 * Host model: drives register, command and sample strobes of the bank.
 * Assumes a free-running clock; the bank samples on the rising edge.
 */
module lmc_host_model (
	input  wire logic        clk_i,
	input  wire logic [7:0]  rdata_i,
	input  wire logic        log_write_i,
	input  wire logic        count_inc_i,
	input  wire logic        wrap_i,
	output logic [15:0]      addr_o,
	output logic             wr_o,
	output logic [7:0]       wdata_o,
	output logic [3:0]       cmd_o,
	output logic             temp_valid_o,
	output logic [7:0]       temp_msb_o,
	output logic             hum_valid_o,
	output logic [7:0]       hum_msb_o,
	output logic             full_o
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		{addr_o, wr_o, wdata_o, cmd_o, temp_valid_o, temp_msb_o, hum_valid_o, hum_msb_o, full_o} = '0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_i);
		#2;
		addr_o = a;
		wr_o = 1'b1;
		wdata_o = d;
		@(posedge clk_i);
		#2;
		wr_o = 1'b0;
		// Stale data never looks valid
		wdata_o = ~d;
	endtask

	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk_i);
		#2;
		addr_o = a;
		@(posedge clk_i);
		#1;
		d = rdata_i;
	endtask

	// One-cycle strobe; returns {log write, count, wrap} of the next cycle
	task automatic pulse(input logic [3:0] c, input logic tv, input logic [7:0] tm, input logic hv,
		input logic [7:0] hm, input logic f, output logic [2:0] seen);
		@(posedge clk_i);
		#2;
		cmd_o = c;
		temp_valid_o = tv;
		temp_msb_o = tm;
		hum_valid_o = hv;
		hum_msb_o = hm;
		full_o = f;
		@(posedge clk_i);
		#2;
		cmd_o = '0;
		temp_valid_o = 1'b0;
		hum_valid_o = 1'b0;
		full_o = 1'b0;
		temp_msb_o = ~tm;
		hum_msb_o = ~hm;
		seen = {log_write_i, count_inc_i, wrap_i};
	endtask
endmodule

/* testbench.sv */
/*
 * Self-checking bench of the mission control register bank.
 * Assumes the host model drives all bank inputs but clock and reset; one 40 MHz clock.
 */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import lmc_pkg::*;

	logic        clk, rst_n, wr, tv, hv, full, osc, unit, act, conv, c8, tw, hw, lw, inc, wrap;
	logic [15:0] addr, tb, hb;
	logic [7:0]  wdata, rdata, tm, hm, d, v;
	logic [3:0]  cmd;
	logic [2:0]  s;
	lmc_state_t  state;
	int          fails = 0;
	int          n_checks = 0;
	localparam logic [3:0] CLR = 4'h1, GO = 4'h2, STOP = 4'h4, FORCE = 4'h8;

	lmc_host_model host (.clk_i(clk), .rdata_i(rdata), .log_write_i(lw), .count_inc_i(inc), .wrap_i(wrap),
		.addr_o(addr), .wr_o(wr), .wdata_o(wdata), .cmd_o(cmd), .temp_valid_o(tv), .temp_msb_o(tm),
		.hum_valid_o(hv), .hum_msb_o(hm), .full_o(full));

	lmc_regs dut (.clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata),
		.reg_rdata_o(rdata), .cmd_clear_mem_i(cmd[0]), .cmd_start_i(cmd[1]), .cmd_stop_i(cmd[2]),
		.cmd_force_conv_i(cmd[3]), .temp_valid_i(tv), .temp_msb_i(tm), .hum_valid_i(hv), .hum_msb_i(hm),
		.log_full_i(full), .osc_enable_o(osc), .sample_unit_seconds_o(unit), .mission_active_o(act),
		.conv_enable_o(conv), .conv_8bit_o(c8), .temp_wide_o(tw), .hum_wide_o(hw), .log_write_o(lw),
		.sample_count_inc_o(inc), .log_wrap_o(wrap), .temp_base_o(tb), .hum_base_o(hb), .state_o(state));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		host.rd(a, d);
		check({8'h00, d}, {8'h00, e});
	endtask

	task automatic smp(input logic t, input logic [7:0] tmv, input logic h, input logic [7:0] hmv);
		host.pulse(4'h0, t, tmv, h, hmv, 1'b0, s);
	endtask

	task automatic test_done;
		if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Watchdog: the whole sequence is far shorter than this
	initial begin
		repeat (4000) @(posedge clk);
		fails++;
		test_done;
	end

	////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		repeat (6) @(posedge clk);
		#2;
		rst_n = 1'b1;
		rc(LMC_ADDR_ALARM_FLAGS, 8'hF0);
		rc(LMC_ADDR_MISSION_STATE, 8'hC0);
		host.wr(LMC_ADDR_OSC_CTL, 8'hFF);
		rc(LMC_ADDR_OSC_CTL, 8'h03);
		check({14'h0, osc, unit}, 16'h0003);
		host.wr(LMC_ADDR_OSC_CTL, 8'h01);
		check({14'h0, osc, unit}, 16'h0002);
		host.wr(LMC_ADDR_OSC_CTL, 8'h00);
		check({15'h0, osc}, 16'h0000);
		host.pulse(FORCE, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		check({15'h0, osc}, 16'h0001);
		host.wr(LMC_ADDR_ALARM_FLAGS, 8'h00);
		rc(LMC_ADDR_ALARM_FLAGS, 8'hF0);
		rc(16'h0300, 8'h00);
		for (int i = 0; i < 16; i++) begin
			v = 8'(i);
			host.wr(LMC_ADDR_LOG_SETUP, 8'h30 | v);
			rc(LMC_ADDR_LOG_SETUP, 8'hF0 | v);
			check({14'h0, tw, hw}, {14'h0, v[2], v[3]});
			if (v[0]) check(tb, 16'h1000);
			if (v[1]) check(hb, !v[0] ? 16'h1000 : (v[2] == v[3]) ? 16'h2000 : v[3] ? 16'h1A00 : 16'h2400);
		end
		// Temp high and humidity low alarms only
		host.wr(LMC_ADDR_TEMP_LO_THR, 8'h40);
		host.wr(LMC_ADDR_TEMP_HI_THR, 8'h80);
		host.wr(LMC_ADDR_HUM_LO_THR, 8'h30);
		host.wr(LMC_ADDR_HUM_HI_THR, 8'h90);
		host.wr(LMC_ADDR_TEMP_CTL, 8'h02);
		host.wr(LMC_ADDR_HUM_CTL, 8'h01);
		host.wr(LMC_ADDR_OSC_CTL, 8'h00);
		host.wr(LMC_ADDR_LOG_SETUP, 8'h00);
		host.pulse(CLR, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_ALARM_FLAGS, 8'h70);
		rc(LMC_ADDR_MISSION_STATE, 8'hC8);
		host.pulse(GO, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		check({14'h0, act, osc}, 16'h0001);
		// Host sets a log enable before starting
		host.wr(LMC_ADDR_LOG_SETUP, 8'h03);
		host.pulse(GO, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_MISSION_STATE, 8'hC2);
		host.wr(LMC_ADDR_OSC_CTL, 8'h00);
		check({15'h0, osc}, 16'h0001);
		host.wr(LMC_ADDR_LOG_SETUP, 8'h0F);
		rc(LMC_ADDR_LOG_SETUP, 8'hC3);
		smp(1'b1, 8'h41, 1'b1, 8'h60);
		check({13'h0, s}, 16'h0006);
		smp(1'b1, 8'h40, 1'b0, 8'h00);
		smp(1'b1, 8'h80, 1'b0, 8'h00);
		smp(1'b0, 8'h00, 1'b1, 8'h90);
		smp(1'b0, 8'h00, 1'b1, 8'h30);
		rc(LMC_ADDR_ALARM_FLAGS, 8'h76);
		smp(1'b1, 8'h60, 1'b1, 8'h60);
		host.pulse(CLR, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_ALARM_FLAGS, 8'h76);
		host.pulse(4'h0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, s);
		check({12'h0, state}, {12'h0, LMC_HALT});
		check({14'h0, act, conv}, 16'h0002);
		host.pulse(STOP, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		check({15'h0, act}, 16'h0000);
		// Second mission waits for a temperature alarm
		host.pulse(CLR, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_ALARM_FLAGS, 8'h70);
		host.wr(LMC_ADDR_LOG_SETUP, 8'h31);
		host.pulse(GO, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_MISSION_STATE, 8'hD2);
		check({15'h0, c8}, 16'h0001);
		smp(1'b1, 8'h50, 1'b0, 8'h00);
		check({13'h0, s}, 16'h0000);
		smp(1'b1, 8'h80, 1'b0, 8'h00);
		check({13'h0, s}, 16'h0004);
		check({15'h0, c8}, 16'h0000);
		rc(LMC_ADDR_MISSION_STATE, 8'hC2);
		smp(1'b1, 8'h50, 1'b0, 8'h00);
		check({13'h0, s}, 16'h0006);
		host.pulse(4'h0, 1'b0, 8'h00, 1'b0, 8'h00, 1'b1, s);
		check({13'h0, s}, 16'h0001);
		check({12'h0, state}, {12'h0, LMC_LOG});
		// Awaiting survives stop and clear; start bit alone needs temperature logging
		host.pulse(STOP, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		host.pulse(CLR, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		host.pulse(GO, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		host.pulse(STOP, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_MISSION_STATE, 8'hD0);
		host.pulse(CLR, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		rc(LMC_ADDR_MISSION_STATE, 8'hD8);
		host.wr(LMC_ADDR_LOG_SETUP, 8'h22);
		host.pulse(GO, 1'b0, 8'h00, 1'b0, 8'h00, 1'b0, s);
		check({12'h0, state}, {12'h0, LMC_LOG});
		check({15'h0, c8}, 16'h0000);
		test_done;
	end
endmodule
